// ==== core/gpio_pin_function_mux.sv ====
/*
 Function multiplexer for general-purpose pins 5 to 18: boot-time UART
 routing, optional serial-memory I2C on pins 14/15, and GPIO once configured.
 Assumes a decoded one-cycle configuration strobe from the UART command path
 and pads that resolve the wire from out, oe and pull-up.
*/
// Notes on behaviour
// - Pin 6 drives UART transmit after boot.
// - Pin 7 is UART receive, no pull.
// - Pin 8 drives active-low request-to-send after boot.
// - Pin 9 is active-low clear-to-send input, unpulled.
// - Pin 14 pulled input, then I2C clock.
// - Pin 15 pulled input, then I2C data.
// - Other pins pulled inputs until configured GPIO.
`timescale 1ns/1ps
module gpio_pin_function_mux
    import pin_mux_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Pads of pins 5 to 18, bit 0 is pin 5
    input wire logic [13:0] pad_in,
    output logic [13:0] pad_out,
    output logic [13:0] pad_oe,
    output logic [13:0] pad_pullup,
    // Host UART core
    input wire logic uart_tx,
    input wire logic request_to_send_n,
    output logic uart_rx,
    output logic clear_to_send_n,
    // Serial memory I2C controller, open drain
    input wire logic scl_drive_low,
    input wire logic sda_drive_low,
    output logic scl_in,
    output logic sda_in,
    // Decoded configuration command
    input wire logic cfg_valid,
    input wire logic cfg_mem_i2c,
    input wire logic [13:0] cfg_gpio_oe,
    input wire logic [13:0] cfg_gpio_out,
    // GPIO view for software
    output logic [13:0] gpio_in,
    output logic configured
);
    logic [13:0] pin_s;
    // Configuration state
    logic configured_q;
    logic mem_i2c_q;
    logic [13:0] gpio_oe_q;
    logic [13:0] gpio_out_q;
    // Pad drive, registered so the outputs leave flops
    logic [13:0] out_q;
    logic [13:0] out_d;
    logic [13:0] oe_q;
    logic [13:0] oe_d;
    logic [13:0] pull_q;
    logic [13:0] pull_d;
    logic [13:0] gin_q;
    logic rx_q;
    logic cts_q;
    logic scl_q;
    logic sda_q;

    // Serial memory owns pins 14/15 only after a command that asks for it
    wire i2c_on = configured_q && mem_i2c_q;
    wire [13:0] scl_bit = 14'h0001 << IDX_SCL;
    wire [13:0] sda_bit = 14'h0001 << IDX_SDA;
    wire [13:0] i2c_pins = {14{mem_i2c_q}} & (scl_bit | sda_bit);
    // Pins 14/15 fall back to GPIO when the serial memory is not wanted
    wire [13:0] gpio_sel = configured_q ? (GPIO_CAPABLE & ~i2c_pins) : 14'h0000;
    // Inputs keep their pull-up, outputs drop it
    wire [13:0] gpio_pull = ~gpio_oe_q;
    wire [13:0] gpio_seen = pin_s & gpio_sel;
    // Controller sees an idle bus until the pins are handed over
    wire scl_seen = i2c_on ? pin_s[IDX_SCL] : 1'b1;
    wire sda_seen = i2c_on ? pin_s[IDX_SDA] : 1'b1;

    // Every pad passes two flops before any logic reads it
    genvar g;
    generate
        for (g = 0; g < NPINS; g++)
        begin : g_sync
            pin_sync u_sync (
                .clk(clk),
                .resetn(resetn),
                .d(pad_in[g]),
                .q(pin_s[g])
            );
        end
    endgenerate

    // The flag only sets; reset is the sole way back to boot defaults
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            configured_q <= RST_CONFIGURED;
        else if (cfg_valid)
            configured_q <= 1'b1;
    end

    // Only a decoded command moves the per-pin state
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            mem_i2c_q <= RST_MEM_I2C;
            gpio_oe_q <= RST_GPIO_OE;
            gpio_out_q <= RST_GPIO_OUT;
        end
        else if (cfg_valid)
        begin
            mem_i2c_q <= cfg_mem_i2c;
            gpio_oe_q <= cfg_gpio_oe & GPIO_CAPABLE;
            gpio_out_q <= cfg_gpio_out;
        end
    end

    always_comb
    begin
        out_d = RST_OUT;
        oe_d = RST_OE;
        pull_d = RST_PULLUP;
        for (int i = 0; i < NPINS; i++)
        begin
            if (gpio_sel[i])
            begin
                out_d[i] = gpio_out_q[i];
                oe_d[i] = gpio_oe_q[i];
                pull_d[i] = gpio_pull[i];
            end
        end
        // Fixed UART roles win over any GPIO setting
        out_d[IDX_UART_TX] = uart_tx;
        oe_d[IDX_UART_TX] = 1'b1;
        oe_d[IDX_UART_RX] = 1'b0;
        pull_d[IDX_UART_RX] = 1'b0;
        out_d[IDX_RTS] = request_to_send_n;
        oe_d[IDX_RTS] = 1'b1;
        oe_d[IDX_CTS] = 1'b0;
        pull_d[IDX_CTS] = 1'b0;
        // Open drain: drive low only, the pad pull-up holds the bus high
        if (i2c_on)
        begin
            out_d[IDX_SCL] = 1'b0;
            oe_d[IDX_SCL] = scl_drive_low;
            pull_d[IDX_SCL] = 1'b1;
            out_d[IDX_SDA] = 1'b0;
            oe_d[IDX_SDA] = sda_drive_low;
            pull_d[IDX_SDA] = 1'b1;
        end
    end

    // Registered pad drive costs one cycle of latency on the UART lines
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            out_q <= RST_OUT;
            oe_q <= RST_OE;
            pull_q <= RST_PULLUP;
        end
        else
        begin
            out_q <= out_d;
            oe_q <= oe_d;
            pull_q <= pull_d;
        end
    end

    // Software view: pins not handed to GPIO read as zero
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            gin_q <= 14'h0000;
        else
            gin_q <= gpio_seen;
    end

    // UART inputs idle high in reset so the core sees no false start
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rx_q <= 1'b1;
            cts_q <= 1'b1;
        end
        else
        begin
            rx_q <= pin_s[IDX_UART_RX];
            cts_q <= pin_s[IDX_CTS];
        end
    end

    // Serial memory lines as the controller sees them
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end
        else
        begin
            scl_q <= scl_seen;
            sda_q <= sda_seen;
        end
    end

    // Pad drive
    assign pad_out = out_q;
    assign pad_oe = oe_q;
    assign pad_pullup = pull_q;

    // Host UART
    assign uart_rx = rx_q;
    assign clear_to_send_n = cts_q;

    // Serial memory
    assign scl_in = scl_q;
    assign sda_in = sda_q;

    // Software view
    assign gpio_in = gin_q;
    assign configured = configured_q;
endmodule

// ==== core/pin_mux_pkg.sv ====
/*
 Constants for the pin function multiplexer of pins 5 to 18.
 Assumes a single system clock domain and an external command decoder.
*/
package pin_mux_pkg;
    localparam int PIN_LO = 5;
    localparam int PIN_HI = 18;
    localparam int NPINS = 14;
    localparam int PIN_UART_TX = 6;
    localparam int PIN_UART_RX = 7;
    localparam int PIN_RTS = 8;
    localparam int PIN_CTS = 9;
    localparam int PIN_SCL = 14;
    localparam int PIN_SDA = 15;
    // Bit position of a pin within the 14-bit vectors
    localparam int IDX_UART_TX = PIN_UART_TX - PIN_LO;
    localparam int IDX_UART_RX = PIN_UART_RX - PIN_LO;
    localparam int IDX_RTS = PIN_RTS - PIN_LO;
    localparam int IDX_CTS = PIN_CTS - PIN_LO;
    localparam int IDX_SCL = PIN_SCL - PIN_LO;
    localparam int IDX_SDA = PIN_SDA - PIN_LO;
    // Boot defaults: only pins 6 and 8 drive; pull-up on all but 6..9
    localparam logic [13:0] RST_OE = 14'h000a;
    localparam logic [13:0] RST_OUT = 14'h000b;
    localparam logic [13:0] RST_PULLUP = 14'h3fe1;
    localparam logic [13:0] RST_GPIO_OE = 14'h0000;
    localparam logic [13:0] RST_GPIO_OUT = 14'h0000;
    localparam logic [13:0] GPIO_CAPABLE = 14'h3fe1;
    localparam logic RST_CONFIGURED = 1'b0;
    localparam logic RST_MEM_I2C = 1'b0;
    localparam logic [1:0] SYNC_RST = 2'h3;
endpackage

// ==== core/pin_sync.sv ====
/*
 Two-flop synchroniser for one pad input.
 Assumes the input is asynchronous to clk; resets to the idle-high level.
*/
`timescale 1ns/1ps
module pin_sync
    import pin_mux_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Pad level
    input wire logic d,
    output logic q
);
    logic [1:0] sync_q;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            sync_q <= SYNC_RST;
        else
            sync_q <= {sync_q[0], d};
    end

    assign q = sync_q[1];
endmodule

// ==== sim/pin_mux_props.sv ====
/* Port checker for the pin mux.
 Assumes one clock and bind by port name. */
`timescale 1ns/1ps
module pin_mux_props
    import pin_mux_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [13:0] pad_in,
    input wire logic [13:0] pad_out,
    input wire logic [13:0] pad_oe,
    input wire logic [13:0] pad_pullup,
    input wire logic uart_tx,
    input wire logic request_to_send_n,
    input wire logic uart_rx,
    input wire logic clear_to_send_n,
    input wire logic cfg_valid,
    input wire logic [13:0] cfg_gpio_oe,
    input wire logic configured
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence up1; $past(resetn); endsequence
    sequence up3; $past(resetn, 3); endsequence
    sequence cfg_once; cfg_valid ##1 !cfg_valid; endsequence
    chk_tx_drive: assert property (up1 |-> pad_oe[1] && pad_out[1] == $past(uart_tx))
        else $error("tx pin");
    chk_rx_sync: assert property (up3 |-> uart_rx == $past(pad_in[IDX_UART_RX], 3))
        else $error("rx pin");
    chk_rts_drive: assert property (up1 |-> pad_oe[3] && pad_out[3] == $past(request_to_send_n))
        else $error("rts pin");
    chk_cts_sync: assert property (up3 |-> clear_to_send_n == $past(pad_in[IDX_CTS], 3))
        else $error("cts pin");
    chk_uart_nopull: assert property (pad_pullup[4:1] == 4'h0 && !pad_oe[2] && !pad_oe[4])
        else $error("uart pins pulled");
    chk_boot_pins: assert property (!configured |-> pad_oe == RST_OE && pad_pullup == RST_PULLUP)
        else $error("boot pins");
    chk_cfg_sets: assert property (cfg_valid |=> configured)
        else $error("no config flag");
    chk_cfg_cause: assert property ($rose(configured) |-> $past(cfg_valid))
        else $error("flag without command");
    chk_gpio_apply: assert property (cfg_once |=> pad_oe[0] == $past(cfg_gpio_oe[0], 2))
        else $error("pin 5 direction");
endmodule
bind gpio_pin_function_mux pin_mux_props u_pin_mux_props (.*);

// ==== sim/pad_board_model.sv ====
/* Board wires of pins 5 to 18.
 Assumes the host drives a pin only where ext_oe is set. */
`timescale 1ns/1ps
module pad_board_model
(
    input wire logic [13:0] pad_out,
    input wire logic [13:0] pad_oe,
    input wire logic [13:0] pad_pullup,
    input wire logic [13:0] ext_drive,
    input wire logic [13:0] ext_oe,
    output logic [13:0] pad_in
);
    // Host drives rx and cts; undriven pulled lines read high
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_oe & ext_drive) | (~pad_oe & ~ext_oe & pad_pullup);
endmodule

// ==== sim/tb.sv ====
/* Self-checking bench for the pin mux.
 Assumes the board model resolves each pad. */
`timescale 1ns/1ps
module tb;
    import pin_mux_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic uart_tx = 1'b1;
    logic request_to_send_n = 1'b1;
    logic scl_drive_low = 1'b0;
    logic sda_drive_low = 1'b0;
    logic cfg_valid = 1'b0;
    logic cfg_mem_i2c = 1'b0;
    logic [13:0] cfg_gpio_oe = 14'h0000;
    logic [13:0] cfg_gpio_out = 14'h0000;
    logic [13:0] ext_drive = 14'h0004;
    logic [13:0] ext_oe = 14'h0014;
    logic [13:0] pad_in, pad_out, pad_oe, pad_pullup, gpio_in;
    logic uart_rx, clear_to_send_n, scl_in, sda_in, configured;
    int errors = 0;
    int checks = 0;
    gpio_pin_function_mux u_gpio_pin_function_mux (.*);
    pad_board_model u_pad_board_model (.*);
    initial
    begin
        forever #2 clk = ~clk;
    end
    task automatic chk(input logic [13:0] got, input logic [13:0] exp);
        checks++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic complete_run;
        $display("errors=%0d checks=%0d", errors, checks);
        if (errors == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic send_cfg(input logic i2c, input logic [13:0] oe, input logic [13:0] out);
        cfg_mem_i2c = i2c;
        cfg_gpio_oe = oe;
        cfg_gpio_out = out;
        cfg_valid = 1'b1;
        tick(1);
        cfg_valid = 1'b0;
        tick(4);
    endtask
    task automatic t_boot;
        tick(4);
        chk(pad_oe, 14'h000a);
        chk(pad_pullup, 14'h3fe1);
        chk({uart_rx, clear_to_send_n, configured}, 14'h0004);
    endtask
    task automatic t_uart;
        uart_tx = 1'b0;
        request_to_send_n = 1'b0;
        tick(4);
        chk(pad_out & 14'h000a, 14'h0000);
        uart_tx = 1'b1;
        ext_drive = 14'h0010;
        tick(4);
        chk(pad_out & 14'h000a, 14'h0002);
        chk({uart_rx, clear_to_send_n}, 14'h0001);
    endtask
    task automatic t_i2c;
        scl_drive_low = 1'b1;
        send_cfg(1'b1, 14'h3fff, 14'h0000);
        chk(pad_oe, 14'h3beb);
        chk(pad_pullup, 14'h0600);
        chk({scl_in, sda_in}, 14'h0001);
        scl_drive_low = 1'b0;
        sda_drive_low = 1'b1;
        tick(4);
        chk(pad_oe, 14'h3deb);
        chk({scl_in, sda_in}, 14'h0002);
        sda_drive_low = 1'b0;
    endtask
    task automatic t_gpio;
        ext_oe = 14'h0094;
        send_cfg(1'b0, 14'h0001, 14'h0001);
        chk(pad_oe, 14'h000b);
        chk(pad_pullup, 14'h3fe0);
        chk(gpio_in, 14'h3f61);
    endtask
    initial
    begin
        tick(4);
        resetn = 1'b1;
        t_boot();
        t_uart();
        t_i2c();
        t_gpio();
        complete_run();
    end
endmodule
